// ### shared/ict_pkg.sv
// Package: instruction timing classes, table entries and time constants
package ict_pkg;

    // Time state period and the system clock that paces it
    localparam int unsigned TSTATE_NS    = 400;
    localparam int unsigned CLK_NS       = 25;
    localparam int unsigned TICK_CYCLES  = (TSTATE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  TICK_LAST    = 4'(TICK_CYCLES - 1);
    localparam logic [3:0]  TICK_RESET   = 4'h0;

    // Automatic wait state added to direct and indirect port accesses; port block entries get none
    localparam logic [4:0]  IO_AUTO_WAIT = 5'h01;

    // Reset values of counters and result fields
    localparam logic [7:0]  COUNT_RESET  = 8'h00;
    localparam logic [19:0] NS_RESET     = 20'h00000;

    typedef enum logic [4:0] {
        ICT_LD_A_IR       = 5'h00,  // Accumulator to/from vector or refresh register
        ICT_ADC_SBC_PTR   = 5'h01,  // Add/subtract with carry into memory_pointer_pair
        ICT_LD_IDX_IMM    = 5'h02,  // Immediate 16-bit into an index register
        ICT_LD_SP_IDX     = 5'h03,  // stack_pointer from an index register
        ICT_LD_PAIR_DIR   = 5'h04,  // Pair, stack_pointer or index to/from direct memory
        ICT_POP_PAIR      = 5'h05,  // Pop general pair
        ICT_POP_IDX       = 5'h06,  // Pop index register
        ICT_INC_DEC_IDX   = 5'h07,  // Increment/decrement index register
        ICT_BANK_SWAP     = 5'h08,  // Alternate bank swap
        ICT_EX_SP_IDX     = 5'h09,  // Top of stack with index register
        ICT_IO_DIRECT     = 5'h0A,  // Port number in instruction
        ICT_IO_INDIRECT   = 5'h0B,  // Port number from register
        ICT_DIGIT_ROT     = 5'h0C,  // Digit rotate with memory
        ICT_JP_COND       = 5'h0D,  // Conditional direct jump
        ICT_JR_COND       = 5'h0E,  // Conditional relative jump
        ICT_CALL_COND     = 5'h0F,  // Conditional subroutine call
        ICT_RET_COND      = 5'h10,  // Conditional subroutine return
        ICT_LOOP_DEC      = 5'h11,  // Decrement and loop
        ICT_BLOCK_MOVE    = 5'h12   // Block move / search / port block
    } ict_class_t;

    typedef struct packed {
        ict_class_t cls;            // Instruction class
        logic       cond;           // Condition met, or block counter not yet expired
    } ict_req_t;

    typedef struct packed {
        logic [2:0] bytes;          // Instruction length in bytes
        logic [2:0] cycles;         // Machine cycles
        logic [4:0] states;         // Minimum time states
        logic       io;             // Has a port access machine cycle
    } ict_timing_t;

    typedef enum logic [1:0] {
        ICT_IDLE = 2'b00,
        ICT_RUN  = 2'b01,
        ICT_DONE = 2'b11
    } ict_state_t;

endpackage

// ### logic/ict_timing_lookup.sv
// Instruction class to bytes, machine cycles and time states
`timescale 1ns/1ps
module ict_timing_lookup
(
    input  ict_pkg::ict_req_t    i_req,    // Class and condition
    output ict_pkg::ict_timing_t o_timing  // Table entry
);
    import ict_pkg::*;

    function automatic ict_timing_t entry(input logic [2:0] b, input logic [2:0] c,
                                          input logic [4:0] s, input logic io);
        entry = '{bytes: b, cycles: c, states: s, io: io};
    endfunction

    function automatic ict_timing_t decode(input ict_req_t r);
        case (r.cls)
            ICT_LD_A_IR:     decode = entry(3'h2, 3'h2, 5'h09, 1'b0);
            ICT_ADC_SBC_PTR: decode = entry(3'h2, 3'h4, 5'h0F, 1'b0);
            ICT_LD_IDX_IMM:  decode = entry(3'h4, 3'h4, 5'h0E, 1'b0);
            ICT_LD_SP_IDX:   decode = entry(3'h2, 3'h2, 5'h0A, 1'b0);
            ICT_LD_PAIR_DIR: decode = entry(3'h4, 3'h6, 5'h14, 1'b0);
            ICT_POP_PAIR:    decode = entry(3'h1, 3'h3, 5'h0A, 1'b0);
            ICT_POP_IDX:     decode = entry(3'h2, 3'h4, 5'h0E, 1'b0);
            ICT_INC_DEC_IDX: decode = entry(3'h2, 3'h2, 5'h0A, 1'b0);
            ICT_BANK_SWAP:   decode = entry(3'h1, 3'h1, 5'h04, 1'b0);
            ICT_EX_SP_IDX:   decode = entry(3'h2, 3'h6, 5'h17, 1'b0);
            // Port entries hold the minimum; the automatic wait is added on start
            ICT_IO_DIRECT:   decode = entry(3'h2, 3'h3, 5'h0A, 1'b1);
            ICT_IO_INDIRECT: decode = entry(3'h2, 3'h3, 5'h0B, 1'b1);
            ICT_DIGIT_ROT:   decode = entry(3'h2, 3'h5, 5'h12, 1'b0);
            ICT_JP_COND:     decode = entry(3'h3, 3'h3, 5'h0A, 1'b0);
            ICT_JR_COND:     decode = r.cond ? entry(3'h2, 3'h3, 5'h0C, 1'b0)
                                             : entry(3'h2, 3'h2, 5'h07, 1'b0);
            ICT_CALL_COND:   decode = r.cond ? entry(3'h3, 3'h5, 5'h11, 1'b0)
                                             : entry(3'h3, 3'h3, 5'h0A, 1'b0);
            ICT_RET_COND:    decode = r.cond ? entry(3'h1, 3'h3, 5'h0B, 1'b0)
                                             : entry(3'h1, 3'h1, 5'h05, 1'b0);
            ICT_LOOP_DEC:    decode = r.cond ? entry(3'h2, 3'h3, 5'h0D, 1'b0)
                                             : entry(3'h2, 3'h2, 5'h08, 1'b0);
            ICT_BLOCK_MOVE:  decode = r.cond ? entry(3'h2, 3'h5, 5'h15, 1'b0)
                                             : entry(3'h2, 3'h4, 5'h10, 1'b0);
            default:         decode = entry(3'h1, 3'h1, 5'h04, 1'b0);
        endcase
    endfunction

    assign o_timing = decode(i_req);

endmodule

// ### logic/ict_cycle_timer.sv
// Instruction execution timer: paces time states and reports duration
`timescale 1ns/1ps
module ict_cycle_timer
(
    input  wire logic              i_clk_sys,              // 40 MHz system clock
    input  wire logic              i_resetn,               // Async reset, active low
    input  wire logic              i_start,                // Begin an instruction (taken when idle)
    input  ict_pkg::ict_req_t      i_req,                  // Class and condition
    input  wire logic              i_wait_request_line_n,  // External wait, active low
    output logic                   o_busy,                 // Instruction in progress
    output logic                   o_done,                 // One-cycle pulse at completion
    output logic                   o_tstate,               // One-cycle pulse per time state
    output logic                   o_waiting,              // Last time state was a wait
    output logic [2:0]             o_bytes,                // Bytes of current instruction
    output logic [2:0]             o_cycles,               // Machine cycles
    output logic [4:0]             o_states,               // Time states incl. automatic wait
    output logic [7:0]             o_elapsed,              // Time states spent incl. waits
    output logic [7:0]             o_waits,                // External wait states inserted
    output logic [19:0]            o_exec_ns               // Execution time in ns
);
    import ict_pkg::*;

    ict_timing_t    look;
    ict_state_t     state_reg;
    logic [3:0]     div_reg;
    logic [4:0]     remain_reg;
    logic           accept;
    logic           tick;
    logic           stall;
    logic           last;

    ict_timing_lookup u_lookup (
        .i_req    (i_req),
        .o_timing (look)
    );

    function automatic logic [19:0] ns_of(input logic [7:0] n);
        ns_of = 20'(n) * 20'(TSTATE_NS);
    endfunction

    assign accept = (state_reg == ICT_IDLE) && i_start;
    assign tick   = (state_reg == ICT_RUN) && (div_reg == TICK_LAST);
    assign stall  = tick && !i_wait_request_line_n;
    assign last   = tick && !stall && (remain_reg == 5'h01);

    // Divider restarts on each start so the first time state is full length
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            div_reg <= TICK_RESET;
        end else if (accept || div_reg == TICK_LAST) begin
            div_reg <= TICK_RESET;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ICT_IDLE;
        end else begin
            case (state_reg)
                ICT_IDLE: begin
                    if (i_start) begin
                        state_reg <= ICT_RUN;
                    end
                end
                ICT_RUN: begin
                    if (last) begin
                        state_reg <= ICT_DONE;
                    end
                end
                ICT_DONE: begin
                    state_reg <= ICT_IDLE;
                end
                default: begin
                    state_reg <= ICT_IDLE;
                end
            endcase
        end
    end

    // Remaining time states; a wait holds the count unchanged
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            remain_reg <= 5'h00;
        end else if (accept) begin
            remain_reg <= look.states + (look.io ? IO_AUTO_WAIT : 5'h00);
        end else if (tick && !stall) begin
            remain_reg <= remain_reg - 5'h01;
        end
    end

    // Latched instruction figures
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bytes  <= 3'h0;
            o_cycles <= 3'h0;
            o_states <= 5'h00;
        end else if (accept) begin
            o_bytes  <= look.bytes;
            o_cycles <= look.cycles;
            o_states <= look.states + (look.io ? IO_AUTO_WAIT : 5'h00);
        end
    end

    // Elapsed and wait counts; every tick, wait or not, is one time state
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_elapsed <= COUNT_RESET;
            o_waits   <= COUNT_RESET;
            o_waiting <= 1'b0;
        end else if (accept) begin
            o_elapsed <= COUNT_RESET;
            o_waits   <= COUNT_RESET;
            o_waiting <= 1'b0;
        end else if (tick) begin
            o_elapsed <= o_elapsed + 8'h01;
            o_waiting <= stall;
            if (stall) begin
                o_waits <= o_waits + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_busy    <= 1'b0;
            o_done    <= 1'b0;
            o_tstate  <= 1'b0;
            o_exec_ns <= NS_RESET;
        end else begin
            o_busy   <= accept || (o_busy && !last);
            o_done   <= last;
            o_tstate <= tick;
            if (last) begin
                o_exec_ns <= ns_of(o_elapsed + 8'h01);
            end
        end
    end

    // Checks on table figures, pacing and wait behaviour
    ld_ir_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_LD_A_IR |=> o_bytes == 3'h2 && o_cycles == 3'h2 && o_states == 5'h09)
        else $error("vector/refresh move timing wrong");
    adc_ptr_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_ADC_SBC_PTR |=> o_cycles == 3'h4 && o_states == 5'h0F)
        else $error("carry add timing wrong");
    ld_idx_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_LD_IDX_IMM |=> o_bytes == 3'h4 && o_states == 5'h0E)
        else $error("index immediate timing wrong");
    sp_idx_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_LD_SP_IDX |=> o_cycles == 3'h2 && o_states == 5'h0A)
        else $error("stack pointer load timing wrong");
    pair_dir_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_LD_PAIR_DIR |=> o_states == 5'h14)
        else $error("direct pair load timing wrong");
    pop_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls inside {ICT_POP_PAIR, ICT_POP_IDX}
        |=> o_states == (o_bytes == 3'h1 ? 5'h0A : 5'h0E))
        else $error("pop timing wrong");
    idx_inc_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_INC_DEC_IDX |=> o_bytes == 3'h2 && o_states == 5'h0A)
        else $error("index increment timing wrong");
    bank_swap_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_BANK_SWAP |=> o_cycles == 3'h1 && o_states == 5'h04)
        else $error("bank swap timing wrong");
    ex_stack_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_EX_SP_IDX |=> o_cycles == 3'h6 && o_states == 5'h17)
        else $error("stack exchange timing wrong");
    io_direct_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_IO_DIRECT |=> o_cycles == 3'h3 && o_states == 5'h0B)
        else $error("direct port timing wrong");
    io_indir_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_IO_INDIRECT |=> o_states == 5'h0C)
        else $error("indirect port timing wrong");
    digit_rot_fig_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_DIGIT_ROT |=> o_cycles == 3'h5 && o_states == 5'h12)
        else $error("digit rotate timing wrong");
    cond_call_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && i_req.cls == ICT_CALL_COND |=> o_states == ($past(i_req.cond) ? 5'h11 : 5'h0A))
        else $error("conditional call duration wrong");
    tick_pace_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(o_busy) |-> !tick [*8] ##1 !tick [*7] ##1 tick)
        else $error("time state not 400 ns");
    exec_time_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_done |-> o_exec_ns == 20'(o_elapsed) * 20'h00190)
        else $error("execution time not states times 400 ns");
    io_auto_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        accept && look.io |=> o_states == $past(look.states) + 5'h01)
        else $error("port cycle missing automatic wait");
    wait_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        stall |=> remain_reg == $past(remain_reg) && o_waits == $past(o_waits) + 8'h01)
        else $error("wait state changed progress");
    total_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_done |-> o_elapsed == 8'(o_states) + o_waits)
        else $error("elapsed states do not match table plus waits");

endmodule

// ### tb/ict_bus_card.sv
// Backplane card model: requests a commanded number of wait states per instruction
`timescale 1ns/1ps
module ict_bus_card (
    input  wire logic       i_clk_sys,             // System clock
    input  wire logic       i_resetn,              // Async reset, active low
    input  wire logic       i_busy,                // Instruction running
    input  wire logic       i_tstate,              // Time state pulse
    input  wire logic [7:0] i_wait_cnt,            // Wait states to request
    output logic            o_wait_request_line_n  // Wait request, active low
);
    logic [7:0] seen_reg;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            seen_reg <= 8'h00;
        end else if (!i_busy) begin
            seen_reg <= 8'h00;
        end else if (i_tstate) begin
            seen_reg <= seen_reg + 8'h01;
        end
    end

    // Pulled-up line, so released means high; waits stretch the first time states
    assign o_wait_request_line_n = !(i_busy && (seen_reg < i_wait_cnt));
endmodule

// ### tb/cpu_instruction_cycle_timing_test.sv
// Self-checking bench for the instruction timer
`timescale 1ns/1ps
module cpu_instruction_cycle_timing_test;
    import ict_pkg::*;
    typedef struct packed {
        ict_class_t cls;
        logic       cond;
        logic [2:0] b;
        logic [2:0] c;
        logic [4:0] s;
    } ict_row_t;
    localparam ict_row_t ROWS [25] = '{
        '{ICT_LD_A_IR, 1'b0, 3'h2, 3'h2, 5'h09},
        '{ICT_ADC_SBC_PTR, 1'b0, 3'h2, 3'h4, 5'h0F},
        '{ICT_LD_IDX_IMM, 1'b0, 3'h4, 3'h4, 5'h0E},
        '{ICT_LD_SP_IDX, 1'b0, 3'h2, 3'h2, 5'h0A},
        '{ICT_LD_PAIR_DIR, 1'b0, 3'h4, 3'h6, 5'h14},
        '{ICT_POP_PAIR, 1'b0, 3'h1, 3'h3, 5'h0A},
        '{ICT_POP_IDX, 1'b0, 3'h2, 3'h4, 5'h0E},
        '{ICT_INC_DEC_IDX, 1'b0, 3'h2, 3'h2, 5'h0A},
        '{ICT_BANK_SWAP, 1'b0, 3'h1, 3'h1, 5'h04},
        '{ICT_EX_SP_IDX, 1'b0, 3'h2, 3'h6, 5'h17},
        '{ICT_IO_DIRECT, 1'b0, 3'h2, 3'h3, 5'h0B},
        '{ICT_IO_INDIRECT, 1'b0, 3'h2, 3'h3, 5'h0C},
        '{ICT_DIGIT_ROT, 1'b0, 3'h2, 3'h5, 5'h12},
        '{ICT_JP_COND, 1'b1, 3'h3, 3'h3, 5'h0A},
        '{ICT_JP_COND, 1'b0, 3'h3, 3'h3, 5'h0A},
        '{ICT_JR_COND, 1'b1, 3'h2, 3'h3, 5'h0C},
        '{ICT_JR_COND, 1'b0, 3'h2, 3'h2, 5'h07},
        '{ICT_CALL_COND, 1'b1, 3'h3, 3'h5, 5'h11},
        '{ICT_CALL_COND, 1'b0, 3'h3, 3'h3, 5'h0A},
        '{ICT_RET_COND, 1'b1, 3'h1, 3'h3, 5'h0B},
        '{ICT_RET_COND, 1'b0, 3'h1, 3'h1, 5'h05},
        '{ICT_LOOP_DEC, 1'b1, 3'h2, 3'h3, 5'h0D},
        '{ICT_LOOP_DEC, 1'b0, 3'h2, 3'h2, 5'h08},
        '{ICT_BLOCK_MOVE, 1'b1, 3'h2, 3'h5, 5'h15},
        '{ICT_BLOCK_MOVE, 1'b0, 3'h2, 3'h4, 5'h10}
    };

    logic        i_clk_sys;
    logic        i_resetn;
    logic        i_start;
    ict_req_t    i_req;
    logic        wait_n;
    logic [7:0]  waits_cmd;
    logic        o_busy;
    logic        o_done;
    logic        o_tstate;
    logic        o_waiting;
    logic [2:0]  o_bytes;
    logic [2:0]  o_cycles;
    logic [4:0]  o_states;
    logic [7:0]  o_elapsed;
    logic [7:0]  o_waits;
    logic [19:0] o_exec_ns;
    int          fails;
    int          tests_run;
    int          k;

    ict_cycle_timer uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_start(i_start), .i_req(i_req),
        .i_wait_request_line_n(wait_n), .o_busy(o_busy), .o_done(o_done), .o_tstate(o_tstate),
        .o_waiting(o_waiting), .o_bytes(o_bytes), .o_cycles(o_cycles), .o_states(o_states),
        .o_elapsed(o_elapsed), .o_waits(o_waits), .o_exec_ns(o_exec_ns));
    ict_bus_card card (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_busy(o_busy), .i_tstate(o_tstate),
        .i_wait_cnt(waits_cmd), .o_wait_request_line_n(wait_n));

    always #12.5 i_clk_sys = ~i_clk_sys;

    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Entered at a falling edge; returns one cycle after the done pulse
    task automatic run_one(input ict_row_t r, input logic [7:0] nw);
        int cnt;
        int tcnt;
        int wcnt;
        logic [19:0] n;
        n = 20'(r.s) + 20'(nw);
        waits_cmd = nw;
        i_req = '{cls: r.cls, cond: r.cond};
        i_start = 1'b1;
        cnt = 0;
        tcnt = 0;
        wcnt = 0;
        while (o_done !== 1'b1 && cnt < 2000) begin
            @(negedge i_clk_sys);
            cnt++;
            i_start = 1'b0;
            if (o_tstate === 1'b1) tcnt++;
            if (o_tstate === 1'b1 && o_waiting === 1'b1) wcnt++;
            if (cnt == 2) begin
                check("busy", 20'(o_busy), 20'h00001);
                check("bytes", 20'(o_bytes), 20'(r.b));
                check("cycles", 20'(o_cycles), 20'(r.c));
            end
        end
        check("states", 20'(o_states), 20'(r.s));
        check("duration", 20'(cnt), n * 20'h00010 + 20'h00001);
        check("tstates", 20'(tcnt), n);
        check("elapsed", 20'(o_elapsed), n);
        check("waits", 20'(o_waits), 20'(nw));
        check("waiting", 20'(wcnt), 20'(nw));
        check("exec_ns", o_exec_ns, n * 20'h00190);
        check("busy_end", 20'(o_busy), 20'h00000);
        @(negedge i_clk_sys);
    endtask

    initial begin
        #500000;
        fails++;
        complete_run();
    end

    initial begin
        i_clk_sys = 1'b0;
        i_resetn = 1'b0;
        i_start = 1'b0;
        i_req = '{cls: ICT_BANK_SWAP, cond: 1'b0};
        waits_cmd = 8'h00;
        fails = 0;
        tests_run = 0;
        repeat (4) @(negedge i_clk_sys);
        check("rst_busy", 20'(o_busy), 20'h00000);
        check("rst_exec", o_exec_ns, 20'h00000);
        i_resetn = 1'b1;
        @(negedge i_clk_sys);
        for (k = 0; k < 25; k++) begin
            run_one(ROWS[k], 8'h00);
        end
        // External waits on a direct port access, on top of its automatic port wait, and on a bank swap
        run_one(ROWS[10], 8'h02);
        run_one(ROWS[8], 8'h03);
        // Start held high: the changed request must not be taken mid-run
        waits_cmd = 8'h00;
        i_req = '{cls: ICT_EX_SP_IDX, cond: 1'b0};
        i_start = 1'b1;
        @(negedge i_clk_sys);
        i_req = '{cls: ICT_BANK_SWAP, cond: 1'b0};
        k = 0;
        while (o_done !== 1'b1 && k < 2000) begin
            @(negedge i_clk_sys);
            k++;
        end
        check("held_done", 20'(o_done), 20'h00001);
        check("held_states", 20'(o_states), 20'h00017);
        repeat (2) @(negedge i_clk_sys);
        check("next_states", 20'(o_states), 20'h00004);
        i_start = 1'b0;
        k = 0;
        while (o_done !== 1'b1 && k < 2000) begin
            @(negedge i_clk_sys);
            k++;
        end
        check("next_done", 20'(o_done), 20'h00001);
        check("next_exec", o_exec_ns, 20'h00640);
        @(negedge i_clk_sys);
        // Reset in mid-run clears the instruction in progress
        i_req = '{cls: ICT_DIGIT_ROT, cond: 1'b0};
        i_start = 1'b1;
        @(negedge i_clk_sys);
        i_start = 1'b0;
        repeat (50) @(negedge i_clk_sys);
        i_resetn = 1'b0;
        @(negedge i_clk_sys);
        check("mid_busy", 20'(o_busy), 20'h00000);
        check("mid_elapsed", 20'(o_elapsed), 20'h00000);
        i_resetn = 1'b1;
        @(negedge i_clk_sys);
        run_one(ROWS[11], 8'h01);
        complete_run();
    end
endmodule
